// ### hdl/tsb_buffer.v
// Purpose: two-bank time stamp capture buffer with status flags,
//          event counters, command trigger and flag interrupts
// Assumes: all inputs but arst_n_i synchronous to clk_sys_i; capture and event
//          inputs are one-cycle pulses
// Notes: Avalon-MM slave answers with one wait cycle per access
`timescale 1ns/1ps
`include "tsb_defines.vh"

module tsb_buffer #(
	parameter N_EVT = 2,
	parameter TS_BYTES = 10
) (
	input wire clk_sys_i,
	input wire arst_n_i,
	input wire [9:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	input wire [8*TS_BYTES-1:0] ts_data_i,
	input wire internal_capture_i,
	input wire [N_EVT-1:0] external_event_input_i,
	output reg buffer_empty_flag_o,
	output reg buffer_full_flag_o,
	output reg buffer_overwrite_flag_o,
	output reg irq_not_empty_o,
	output reg irq_full_o,
	output reg irq_overwrite_o
);

	// -------------------------------------------------------------------
	// reset release
	// -------------------------------------------------------------------
	reg rst_meta_n;
	reg rst_n;

	// assert at once, release two edges later
	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------
	reg [8*TS_BYTES-1:0] bank6;
	reg [8*TS_BYTES-1:0] bank7;
	reg [7:0] buffer_cfg_reg;
	reg [7:0] command_config_reg;
	reg [`TSB_CNT_W*N_EVT-1:0] external_event_counter_reg;

	wire [7:0] reg_idx;
	wire wr_accept;
	wire rd_accept;
	wire trigger;
	wire flag_reset;
	wire cnt_clear;
	wire capture;
	wire overwrite_mode_select;
	wire [7:0] wr_byte;

	assign reg_idx = avs_address_i[9:2];
	// the access completes at the edge where waitrequest is low
	assign wr_accept = avs_write_i & ~avs_waitrequest_o;
	assign rd_accept = avs_read_i & ~avs_waitrequest_o;
	assign wr_byte = avs_writedata_i[7:0];
	// any write to the trigger register with byte 0 enabled fires the command
	assign trigger = wr_accept & avs_byteenable_i[0] & (reg_idx == `TSB_IDX_CMD_TRG);
	assign flag_reset = trigger & command_config_reg[`TSB_CMD_FLAG_RST_EN];
	assign cnt_clear = trigger & command_config_reg[`TSB_CMD_CNT_CLR_EN];
	// every capture source lands in the same buffer
	assign capture = internal_capture_i | (|external_event_input_i) |
		(trigger & command_config_reg[`TSB_CMD_CAPTURE_EN]);
	assign overwrite_mode_select = buffer_cfg_reg[`TSB_CFG_OVW_MODE];

	// -------------------------------------------------------------------
	// bus handshake
	// -------------------------------------------------------------------
	// one wait cycle, then a released cycle; idle holds waitrequest high
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest_o <= 1'b1;
		end else if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
			avs_waitrequest_o <= 1'b0;
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
	end

	// -------------------------------------------------------------------
	// configuration registers
	// -------------------------------------------------------------------
	// writes land on the byte 0 lane only
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			buffer_cfg_reg <= `TSB_BUF_CFG_RST;
			command_config_reg <= `TSB_CMD_CFG_RST;
		end else if (wr_accept & avs_byteenable_i[0]) begin
			if (reg_idx == `TSB_IDX_BUF_CFG) begin
				buffer_cfg_reg <= wr_byte;
			end
			if (reg_idx == `TSB_IDX_CMD_CFG) begin
				command_config_reg <= wr_byte;
			end
		end
	end

	// -------------------------------------------------------------------
	// flag next values
	// -------------------------------------------------------------------
	reg next_empty;
	reg next_full;
	reg next_ovw;
	reg wr_bank6;
	reg wr_bank7;
	reg base_empty;
	reg base_full;
	reg base_ovw;

	// flag reset first, so a capture in the same cycle is not lost
	always @* begin
		base_empty = buffer_empty_flag_o;
		base_full = buffer_full_flag_o;
		base_ovw = buffer_overwrite_flag_o;
		if (flag_reset) begin
			base_empty = 1'b1;
			base_full = 1'b0;
			base_ovw = 1'b0;
		end
		next_empty = base_empty;
		next_full = base_full;
		next_ovw = base_ovw;
		wr_bank6 = 1'b0;
		wr_bank7 = 1'b0;
		if (capture) begin
			if (base_empty) begin
				wr_bank6 = 1'b1;
				next_empty = 1'b0;
			end else if (!base_full) begin
				wr_bank7 = 1'b1;
				next_full = 1'b1;
			end else begin
				// inhibit mode drops the data and keeps both banks
				wr_bank7 = overwrite_mode_select;
				next_ovw = 1'b1;
			end
		end
	end

	// -------------------------------------------------------------------
	// flags and banks
	// -------------------------------------------------------------------
	// bank reads never touch the flags, only captures and a flag reset do
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			buffer_empty_flag_o <= 1'b1;
			buffer_full_flag_o <= 1'b0;
			buffer_overwrite_flag_o <= 1'b0;
		end else begin
			buffer_empty_flag_o <= next_empty;
			buffer_full_flag_o <= next_full;
			buffer_overwrite_flag_o <= next_ovw;
		end
	end

	// contents stay undefined until a capture writes each bank; no reset needed
	always @(posedge clk_sys_i) begin
		if (wr_bank6) begin
			bank6 <= ts_data_i;
		end
		if (wr_bank7) begin
			bank7 <= ts_data_i;
		end
	end

	// -------------------------------------------------------------------
	// interrupt pulses
	// -------------------------------------------------------------------
	// one pulse per flag event, gated by its enable
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_not_empty_o <= 1'b0;
			irq_full_o <= 1'b0;
			irq_overwrite_o <= 1'b0;
		end else begin
			irq_not_empty_o <= wr_bank6 & buffer_cfg_reg[`TSB_CFG_EMPTY_IEN];
			irq_full_o <= capture & ~base_empty & ~base_full &
				buffer_cfg_reg[`TSB_CFG_FULL_IEN];
			// fires on every capture in full status, not just the first
			irq_overwrite_o <= capture & ~base_empty & base_full &
				buffer_cfg_reg[`TSB_CFG_OVW_IEN];
		end
	end

	// -------------------------------------------------------------------
	// event counters
	// -------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < N_EVT; gi = gi + 1) begin : g_cnt
			// an event in the clearing cycle counts as one
			always @(posedge clk_sys_i or negedge rst_n) begin
				if (!rst_n) begin
					external_event_counter_reg[`TSB_CNT_W*gi +: `TSB_CNT_W] <= 6'h00;
				end else if (cnt_clear) begin
					external_event_counter_reg[`TSB_CNT_W*gi +: `TSB_CNT_W] <=
						{5'h00, external_event_input_i[gi]};
				end else if (external_event_input_i[gi]) begin
					// wraps from 0x3F back to 0x00
					external_event_counter_reg[`TSB_CNT_W*gi +: `TSB_CNT_W] <=
						external_event_counter_reg[`TSB_CNT_W*gi +: `TSB_CNT_W] +
						6'h01;
				end
			end
		end
	endgenerate

	// -------------------------------------------------------------------
	// read mux
	// -------------------------------------------------------------------
	reg [7:0] rd_byte;
	reg [7:0] b6_off;
	reg [7:0] b7_off;
	reg [7:0] ev_off;

	// unmapped indices and the trigger register read as zero
	always @* begin
		rd_byte = 8'h00;
		b6_off = reg_idx - `TSB_IDX_BANK6;
		b7_off = reg_idx - `TSB_IDX_BANK7;
		ev_off = reg_idx - `TSB_IDX_EVCNT;
		if (reg_idx == `TSB_IDX_STATUS) begin
			rd_byte = {5'h00, buffer_overwrite_flag_o, buffer_full_flag_o,
				buffer_empty_flag_o};
		end else if (reg_idx == `TSB_IDX_BUF_CFG) begin
			rd_byte = buffer_cfg_reg;
		end else if (reg_idx == `TSB_IDX_CMD_CFG) begin
			rd_byte = command_config_reg;
		end else if (reg_idx >= `TSB_IDX_BANK6 &&
			b6_off < {4'h0, `TSB_BANK_BYTES}) begin
			rd_byte = bank6[8*b6_off +: 8];
		end else if (reg_idx >= `TSB_IDX_BANK7 &&
			b7_off < {4'h0, `TSB_BANK_BYTES}) begin
			rd_byte = bank7[8*b7_off +: 8];
		end else if (reg_idx >= `TSB_IDX_EVCNT && ev_off < N_EVT) begin
			rd_byte = {2'h0, external_event_counter_reg[`TSB_CNT_W*ev_off +: `TSB_CNT_W]};
		end
	end

	// data registered in the wait cycle, stands in the released cycle only;
	// back to zero once the master has sampled it, so stale data never lingers
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata_o <= 32'h00000000;
		end else if (avs_read_i & avs_waitrequest_o) begin
			avs_readdata_o <= {24'h000000, rd_byte};
		end else begin
			avs_readdata_o <= 32'h00000000;
		end
	end

endmodule // tsb_buffer

// ### hdl/tsb_defines.vh
// Purpose: constants for the two-bank time stamp capture buffer
// Assumes: 32-bit Avalon-MM slave, register index = byte address / 4
// Notes: only the low byte of each register word is used
//
// Operation
// - after reset: empty 1, full 0, overwrite 0
// - flag reset trigger restores flags, keeps banks
// - first capture into bank 6, not empty
// - not-empty interrupt when empty flag falls
// - reading bank 6 leaves empty flag cleared
// - second capture into bank 7, full set
// - full interrupt when full flag rises
// - reading bank 7 leaves full flag set
// - overwrite mode: full capture replaces bank 7
// - overwrite interrupt on each capture when full
// - inhibit mode: discard capture, still set overwrite
// - inhibit mode keeps first two captures
// - six-bit count per external event input
// - counter-clear trigger zeroes all event counters, except one whose event comes in that cycle, which loads 1
`ifndef TSB_DEFINES_VH
`define TSB_DEFINES_VH

// -----------------------------------------------------------------------
// register indices (byte address = 4 * index)
// -----------------------------------------------------------------------
`define TSB_IDX_BANK6 8'h60
`define TSB_IDX_BANK7 8'h70
`define TSB_BANK_BYTES 4'hA
`define TSB_IDX_STATUS 8'h40
`define TSB_IDX_BUF_CFG 8'h41
`define TSB_IDX_CMD_CFG 8'h42
`define TSB_IDX_CMD_TRG 8'h43
`define TSB_IDX_EVCNT 8'h44

// -----------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------
`define TSB_ST_EMPTY 0
`define TSB_ST_FULL 1
`define TSB_ST_OVW 2
`define TSB_CFG_OVW_MODE 0
`define TSB_CFG_EMPTY_IEN 1
`define TSB_CFG_FULL_IEN 2
`define TSB_CFG_OVW_IEN 3
`define TSB_CMD_CAPTURE_EN 0
`define TSB_CMD_CNT_CLR_EN 4
`define TSB_CMD_FLAG_RST_EN 7

// -----------------------------------------------------------------------
// reset values and codes
// -----------------------------------------------------------------------
`define TSB_CLEAR_CODE 8'h90
`define TSB_BUF_CFG_RST 8'h00
`define TSB_CMD_CFG_RST 8'h00
`define TSB_CNT_W 6

// -----------------------------------------------------------------------
// timing: least spacing between command triggers (host side)
// -----------------------------------------------------------------------
`define TSB_TRG_GAP_MS 5
`define TSB_CLK_HZ 25000000

`endif

// ### bench/tsb_buffer_chk.sv
// Purpose: flag, interrupt and bus timing checks for tsb_buffer
// Assumes: the host holds each request until waitrequest is sampled low
// Notes: config registers are not visible here, so enables are not modelled
`timescale 1ns/1ps
module tsb_buffer_chk (
	input wire clk_sys_i,
	input wire arst_n_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_readdata_o,
	input wire avs_waitrequest_o,
	input wire buffer_empty_flag_o,
	input wire buffer_full_flag_o,
	input wire buffer_overwrite_flag_o,
	input wire irq_not_empty_o,
	input wire irq_full_o,
	input wire irq_overwrite_o
);
	// -----------------------------------------------------------------
	// properties
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	// write applied at this edge; only a trigger may drop the flags
	wire acc = avs_write_i && !avs_waitrequest_o;
	chk_empty_irq: assert property (irq_not_empty_o |-> $fell(buffer_empty_flag_o))
		else $error("not-empty pulse without empty fall");
	chk_full_irq: assert property (irq_full_o |-> $rose(buffer_full_flag_o))
		else $error("full pulse without full rise");
	chk_ovw_irq: assert property (irq_overwrite_o |-> buffer_full_flag_o && buffer_overwrite_flag_o)
		else $error("overwrite pulse outside full state");
	chk_pulse_once: assert property (irq_not_empty_o |=> !irq_not_empty_o)
		else $error("not-empty pulse longer than one cycle");
	chk_full_order: assert property (buffer_full_flag_o |-> !buffer_empty_flag_o)
		else $error("full while empty");
	chk_ovw_order: assert property (buffer_overwrite_flag_o |-> buffer_full_flag_o)
		else $error("overwrite while not full");
	chk_empty_hold: assert property ($rose(buffer_empty_flag_o) |-> $past(acc))
		else $error("empty set without trigger write");
	chk_full_hold: assert property ($fell(buffer_full_flag_o) |-> $past(acc))
		else $error("full cleared without trigger write");
	chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("request not answered in one cycle");
	chk_bus_idle: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
		else $error("read data not zero while waiting");
	cov_ovw: cover property (irq_overwrite_o);
	cov_full: cover property (irq_full_o);
	cov_clear: cover property ($rose(buffer_empty_flag_o));
endmodule // tsb_buffer_chk

bind tsb_buffer tsb_buffer_chk tsb_buffer_chk_inst (.clk_sys_i(clk_sys_i),
	.arst_n_i(arst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.buffer_empty_flag_o(buffer_empty_flag_o), .buffer_full_flag_o(buffer_full_flag_o),
	.buffer_overwrite_flag_o(buffer_overwrite_flag_o), .irq_not_empty_o(irq_not_empty_o),
	.irq_full_o(irq_full_o), .irq_overwrite_o(irq_overwrite_o));

// ### bench/tsb_host.sv
// Purpose: host model, Avalon-MM master for the buffer's registers
// Assumes: one access at a time, called from the bench
// Notes: released address and data are inverted so stale values never match
`timescale 1ns/1ps
module tsb_host (
	input wire clk_sys_i,
	input wire [31:0] rdata_i,
	input wire wait_i,
	output logic [9:0] addr_o,
	output logic rd_o,
	output logic wr_o,
	output logic [31:0] wd_o,
	output logic [3:0] be_o
);
	bit tmo = 0;
	initial begin
		{addr_o, rd_o, wr_o, wd_o} = '0;
		be_o = 4'hF;
	end
	// -----------------------------------------------------------------
	// one access: hold until waitrequest sampled low, bounded
	// -----------------------------------------------------------------
	task xfer(input bit w, input [7:0] idx, input [7:0] d, output [31:0] q);
		int n;
		begin
			@(posedge clk_sys_i);
			addr_o <= {idx, 2'b00};
			wd_o <= {24'h0, d};
			wr_o <= w;
			rd_o <= !w;
			n = 0;
			do begin
				@(posedge clk_sys_i);
				n++;
			end while (wait_i !== 1'b0 && n < 20);
			q = rdata_i;
			if (n >= 20) tmo = 1;
			wr_o <= 1'b0;
			rd_o <= 1'b0;
			wd_o <= ~wd_o;
			addr_o <= ~addr_o;
		end
	endtask
endmodule // tsb_host

// ### bench/tb_tsb_buffer.sv
// Purpose: register-level tests of the two-bank time stamp buffer
// Assumes: capture and event pulses last one cycle
// Notes: interrupt pulses are counted and compared in totals
`timescale 1ns/1ps
module tb_tsb_buffer;
	logic clk_sys_i = 0, arst_n_i = 0, cap_int = 0;
	logic [79:0] ts = '0;
	logic [1:0] evt = '0;
	wire [9:0] addr;
	wire rd, wr, wq, ne, fu, ov, f_e, f_f, f_o;
	wire [31:0] wd, rq;
	wire [3:0] be;
	int num_errors = 0, tests_run = 0, n_ne = 0, n_fu = 0, n_ov = 0;
	always #20 clk_sys_i = ~clk_sys_i;
	// pulse counters, one count per registered pulse
	always @(posedge clk_sys_i) begin
		n_ne += ne;
		n_fu += fu;
		n_ov += ov;
	end
	tsb_host tsb_host_inst (.clk_sys_i(clk_sys_i), .rdata_i(rq), .wait_i(wq), .addr_o(addr),
		.rd_o(rd), .wr_o(wr), .wd_o(wd), .be_o(be));
	tsb_buffer tsb_buffer_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(be), .avs_readdata_o(rq), .avs_waitrequest_o(wq), .ts_data_i(ts),
		.internal_capture_i(cap_int), .external_event_input_i(evt),
		.buffer_empty_flag_o(f_e), .buffer_full_flag_o(f_f), .buffer_overwrite_flag_o(f_o),
		.irq_not_empty_o(ne), .irq_full_o(fu), .irq_overwrite_o(ov));
	// -----------------------------------------------------------------
	// tasks
	// -----------------------------------------------------------------
	task close_out;
		$display("errors %0d of %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task acc(input bit w, input [7:0] idx, input [7:0] d, input [31:0] e);
		logic [31:0] q;
		tsb_host_inst.xfer(w, idx, d, q);
		if (tsb_host_inst.tmo) begin
			num_errors++;
			$display("mismatch at %0t: bus hang", $time);
			close_out;
		end
		if (!w) chk(q, e);
	endtask
	// ten byte reads of one bank, a byte per word
	task bank(input [7:0] base, input [79:0] d);
		for (int k = 0; k < 10; k++) acc(0, base + k[7:0], 8'h00, {24'h0, d[8*k+:8]});
	endtask
	// one capture pulse; data inverted after so stale values never match
	task cap(input [79:0] d, input bit ext);
		@(posedge clk_sys_i);
		ts <= d;
		if (ext) evt <= 2'b01;
		else cap_int <= 1'b1;
		@(posedge clk_sys_i);
		cap_int <= 1'b0;
		evt <= 2'b00;
		ts <= ~d;
	endtask
	// clear code leaves command capture off, so no trigger spacing applies
	task clear;
		acc(1, 8'h42, 8'h90, 0);
		acc(1, 8'h43, 8'h00, 0);
	endtask
	// -----------------------------------------------------------------
	// sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		acc(0, 8'h40, 0, 32'h1);
		acc(0, 8'h44, 0, 32'h0);
		acc(0, 8'hFF, 0, 32'h0);
		$display("test reset done");
		acc(1, 8'h41, 8'h0E, 0);
		cap(80'hA0A1A2A3A4A5A6A7A8A9, 1);
		acc(0, 8'h40, 0, 32'h0);
		bank(8'h60, 80'hA0A1A2A3A4A5A6A7A8A9);
		acc(0, 8'h40, 0, 32'h0);
		cap(80'hB0B1B2B3B4B5B6B7B8B9, 0);
		acc(0, 8'h40, 0, 32'h2);
		bank(8'h70, 80'hB0B1B2B3B4B5B6B7B8B9);
		acc(0, 8'h40, 0, 32'h2);
		cap(80'hC0C1C2C3C4C5C6C7C8C9, 1);
		acc(0, 8'h40, 0, 32'h6);
		bank(8'h60, 80'hA0A1A2A3A4A5A6A7A8A9);
		bank(8'h70, 80'hB0B1B2B3B4B5B6B7B8B9);
		acc(0, 8'h44, 0, 32'h2);
		$display("test inhibit done");
		clear;
		acc(0, 8'h40, 0, 32'h1);
		acc(0, 8'h44, 0, 32'h0);
		bank(8'h60, 80'hA0A1A2A3A4A5A6A7A8A9);
		$display("test clear done");
		acc(1, 8'h41, 8'h0F, 0);
		cap(80'hD0D1D2D3D4D5D6D7D8D9, 0);
		cap(80'hE0E1E2E3E4E5E6E7E8E9, 0);
		cap(80'hF0F1F2F3F4F5F6F7F8F9, 1);
		bank(8'h60, 80'hD0D1D2D3D4D5D6D7D8D9);
		bank(8'h70, 80'hF0F1F2F3F4F5F6F7F8F9);
		acc(0, 8'h40, 0, 32'h6);
		chk(n_ne, 2);
		chk(n_fu, 2);
		chk(n_ov, 2);
		$display("test overwrite done");
		clear;
		acc(1, 8'h41, 8'h01, 0);
		cap(80'h0102030405060708090A, 0);
		cap(80'h1112131415161718191A, 0);
		cap(80'h2122232425262728292A, 0);
		chk(n_ne + n_fu + n_ov, 6);
		acc(0, 8'h40, 0, 32'h6);
		$display("test masked done");
		close_out;
	end
endmodule // tb_tsb_buffer
